/* File: ddr3_fe_pkg.sv */
// shared constants and types for the ddr3 command front end
package ddr3_fe_pkg;
  localparam int BANK_W = 3;
  localparam int ADDR_W = 13;
  localparam int COL_W  = 10;
  localparam int DQ_W   = 16;
  localparam int NBANK  = 8;
  localparam int PAGE_BYTES = (1 << COL_W) * DQ_W / 8;
  localparam int CK_HALF = 8;
  localparam logic [3:0] CL_MIN = 4'h5;
  localparam logic [3:0] CL_MAX = 4'hd;
  localparam logic [3:0] CWL_MIN = 4'h5;
  localparam logic [3:0] CWL_MAX = 4'h9;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  localparam logic [1:0] AL_ZERO = 2'h0;
  localparam logic [1:0] AL_CLM1 = 2'h1;
  localparam logic [1:0] AL_CLM2 = 2'h2;
  localparam logic [3:0] CL_RST  = 4'h5;
  localparam logic [3:0] CWL_RST = 4'h5;
  localparam logic [4:0] WR_RST  = 5'h05;
  localparam logic [2:0] MR0_SEL = 3'h0;
  localparam logic [2:0] MR1_SEL = 3'h1;
  localparam logic [2:0] MR2_SEL = 3'h2;
  typedef enum logic [2:0] {
    CMD_NOP, CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD, CMD_ZQ
  } cmd_t;
  typedef enum logic [2:0] {
    PST_IDLE, PST_PPD, PST_APD, PST_SREF
  } pstate_t;
  function automatic logic [3:0] cmd_code(input cmd_t c);
    unique case (c)
      CMD_MRS: cmd_code = 4'h0;
      CMD_REF: cmd_code = 4'h1;
      CMD_PRE: cmd_code = 4'h2;
      CMD_ACT: cmd_code = 4'h3;
      CMD_WR:  cmd_code = 4'h4;
      CMD_RD:  cmd_code = 4'h5;
      CMD_ZQ:  cmd_code = 4'h6;
      CMD_NOP: cmd_code = 4'h7;
    endcase
  endfunction
endpackage

/* File: ddr3_ca_if.sv */
// command, address and data-strobe link between controller and device
`timescale 1ns/1ps
interface ddr3_ca_if;
  import ddr3_fe_pkg::*;
  logic              ck;
  logic              ck_n;
  logic              cke;
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic [BANK_W-1:0] ba;
  logic [ADDR_W-1:0] a;
  logic              odt;
  logic [DQ_W-1:0]   dq_h;
  logic              dqs_h;
  logic              dqs_oe_n_h;
  logic [DQ_W-1:0]   dq_d;
  logic              dqs_d;
  logic              dqs_oe_n_d;
  modport host (output ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, a, odt, dq_h, dqs_h, dqs_oe_n_h,
                input dq_d, dqs_d, dqs_oe_n_d);
  modport dev (input ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, a, odt, dq_h, dqs_h, dqs_oe_n_h,
               output dq_d, dqs_d, dqs_oe_n_d);
endinterface

/* File: ddr3_sync3.sv */
// three-flop synchroniser with agreement check and edge flags
`timescale 1ns/1ps
module ddr3_sync3 #(
  parameter int W = 1
) (
  input  wire logic         i_mclk,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= i_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic lvl_ff;
      // a change counts only once stages two and three agree
      always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          lvl_ff <= 1'b0;
        end else if (s2_ff[g] == s3_ff[g]) begin
          lvl_ff <= s3_ff[g];
        end
      end
      assign o_rise[g]  = (s2_ff[g] == s3_ff[g]) && s3_ff[g] && !lvl_ff;
      assign o_fall[g]  = (s2_ff[g] == s3_ff[g]) && !s3_ff[g] && lvl_ff;
      assign o_level[g] = lvl_ff;
    end
  endgenerate
endmodule

/* File: ddr3_dev_end.sv */
// device end: samples the command link, tracks banks, mode and power state
`timescale 1ns/1ps
// Contract
// - sample inputs on rising ck crossing
// - cke low stops clocks, buffers, drivers; dq_d stays driven here
// - cke low: idle gives ppd/sref, else apd
// - cke clocked for pd entry/exit, sref entry
// - self-refresh exit on cke rise, unclocked
// - controller keeps cke high during accesses
// - power-down keeps ck, odt, cke buffers
// - self-refresh keeps only cke buffer
// - chip select high masks every command
// - command from cs, ras, cas, we
// - eight banks chosen by three-bit address
// - 2KB page, column on a0-a9
// - sixteen-bit data bus
// - data timed by sender's strobe; dq_d goes out here with dqs_d held low
// - data on both strobe edges
// - programmable cl, cwl and additive latency
// - burst 8, chop 4 or on-the-fly; ordering
// - write recovery 5..16 cycles programmable
// - precharge power-down slow or fast exit
// - a10 autoprecharge / all-bank precharge
// - a12 low chops burst when on-the-fly
// - bank address picks bank or mode register
// - a0-a12 carry row, column or opcode
module ddr3_dev_end
  import ddr3_fe_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_arst_n,
  ddr3_ca_if.dev                 link,
  input  wire logic [DQ_W-1:0]   i_rd_data,
  output logic      [3:0]        o_cmd_code,
  output logic                   o_cmd_vld,
  output logic      [BANK_W-1:0] o_cmd_bank,
  output logic      [ADDR_W-1:0] o_cmd_addr,
  output logic                   o_auto_pre,
  output logic                   o_chop,
  output logic      [NBANK-1:0]  o_bank_open,
  output logic      [2:0]        o_pstate,
  output logic                   o_buf_en,
  output logic                   o_odt_on,
  output logic      [3:0]        o_cl,
  output logic      [3:0]        o_cwl,
  output logic      [1:0]        o_al,
  output logic      [1:0]        o_bl_mode,
  output logic                   o_interleave,
  output logic      [4:0]        o_wr_rec,
  output logic                   o_ppd_fast,
  output logic      [DQ_W-1:0]   o_wr_data,
  output logic                   o_wr_vld
);
  localparam int SW = 7 + BANK_W + ADDR_W + 1 + DQ_W;
  logic [SW-1:0] s_lvl;
  logic [SW-1:0] s_rise;
  logic [SW-1:0] s_fall;
  ddr3_sync3 #(.W(SW)) u_sync (
    .i_mclk  (i_mclk),
    .i_arst_n(i_arst_n),
    .i_async ({link.odt, link.ck, link.cke, link.cs_n, link.ras_n, link.cas_n, link.we_n,
               link.ba, link.a, link.dqs_h, link.dq_h}),
    .o_level (s_lvl),
    .o_rise  (s_rise),
    .o_fall  (s_fall)
  );

  logic              odt_s;
  logic              ck_rise;
  logic              cke_s;
  logic              cke_rise_async;
  logic              cs_n_s;
  logic              ras_n_s;
  logic              cas_n_s;
  logic              we_n_s;
  logic [BANK_W-1:0] ba_s;
  logic [ADDR_W-1:0] a_s;
  logic              dqs_edge;
  logic [DQ_W-1:0]   dq_s;
  assign odt_s          = s_lvl[SW-1];
  assign ck_rise        = s_rise[SW-2];
  assign cke_s          = s_lvl[SW-3];
  assign cke_rise_async = s_rise[SW-3];
  assign {cs_n_s, ras_n_s, cas_n_s, we_n_s} = s_lvl[SW-4 -: 4];
  assign ba_s           = s_lvl[SW-8 -: BANK_W];
  assign a_s            = s_lvl[DQ_W+ADDR_W : DQ_W+1];
  assign dqs_edge       = s_rise[DQ_W] | s_fall[DQ_W];
  assign dq_s           = s_lvl[DQ_W-1:0];

  pstate_t    pst_ff;
  logic       cke_prev_ff;
  logic [NBANK-1:0] open_ff;
  logic       wr_window_ff;
  cmd_t       dec;

  // qualified ck edge: only while the power state is idle
  logic live_edge;
  assign live_edge = ck_rise && (pst_ff == PST_IDLE);

  always_comb begin
    dec = CMD_NOP;
    if (!cs_n_s) begin
      unique case ({ras_n_s, cas_n_s, we_n_s})
        3'b000:  dec = CMD_MRS;
        3'b001:  dec = CMD_REF;
        3'b010:  dec = CMD_PRE;
        3'b011:  dec = CMD_ACT;
        3'b100:  dec = CMD_WR;
        3'b101:  dec = CMD_RD;
        3'b110:  dec = CMD_ZQ;
        3'b111:  dec = CMD_NOP;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cmd_vld  <= 1'b0;
      o_cmd_code <= 4'h7;
      o_cmd_bank <= '0;
      o_cmd_addr <= '0;
      o_auto_pre <= 1'b0;
      o_chop     <= 1'b0;
    end else begin
      o_cmd_vld <= 1'b0;
      if (live_edge && cke_s && dec != CMD_NOP) begin
        o_cmd_vld  <= 1'b1;
        o_cmd_code <= cmd_code(dec);
        o_cmd_bank <= ba_s;
        o_cmd_addr <= (dec == CMD_RD || dec == CMD_WR) ? {3'h0, a_s[COL_W-1:0]} : a_s;
        o_auto_pre <= a_s[AP_BIT];
        o_chop     <= (o_bl_mode == BL_FIX4) ||
                      ((o_bl_mode == BL_OTF) && !a_s[BC_BIT]);
      end
    end
  end

  // bank open tracking
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      open_ff <= '0;
    end else if (live_edge && cke_s) begin
      if (dec == CMD_ACT) begin
        open_ff[ba_s] <= 1'b1;
      end else if (dec == CMD_PRE) begin
        if (a_s[AP_BIT]) begin
          open_ff <= '0;
        end else begin
          open_ff[ba_s] <= 1'b0;
        end
      end else if ((dec == CMD_RD || dec == CMD_WR) && a_s[AP_BIT]) begin
        open_ff[ba_s] <= 1'b0;
      end
    end
  end

  // mode registers
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cl         <= CL_RST;
      o_cwl        <= CWL_RST;
      o_al         <= AL_ZERO;
      o_bl_mode    <= BL_FIX8;
      o_interleave <= 1'b0;
      o_wr_rec     <= WR_RST;
      o_ppd_fast   <= 1'b0;
    end else if (live_edge && cke_s && dec == CMD_MRS && open_ff == '0) begin
      unique case (ba_s)
        MR0_SEL: begin
          o_bl_mode    <= (a_s[1:0] == 2'h3) ? BL_FIX8 : a_s[1:0];
          o_interleave <= a_s[3];
          if ({1'b0, a_s[6:4]} + CL_MIN <= CL_MAX) begin
            o_cl <= {1'b0, a_s[6:4]} + CL_MIN;
          end
          o_ppd_fast <= a_s[12];
          unique case (a_s[11:9])
            3'h0: o_wr_rec <= 5'h10;
            3'h1: o_wr_rec <= 5'h05;
            3'h2: o_wr_rec <= 5'h06;
            3'h3: o_wr_rec <= 5'h07;
            3'h4: o_wr_rec <= 5'h08;
            3'h5: o_wr_rec <= 5'h0a;
            3'h6: o_wr_rec <= 5'h0c;
            3'h7: o_wr_rec <= 5'h0e;
          endcase
        end
        MR1_SEL: begin
          if (a_s[4:3] != 2'h3) begin
            o_al <= a_s[4:3];
          end
        end
        MR2_SEL: begin
          if ({1'b0, a_s[5:3]} + CWL_MIN <= CWL_MAX) begin
            o_cwl <= {1'b0, a_s[5:3]} + CWL_MIN;
          end
        end
        default: ;
      endcase
    end
  end

  // power state: entry and pd exit on ck edges, sref exit on cke alone
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pst_ff      <= PST_IDLE;
      cke_prev_ff <= 1'b0;
    end else begin
      if (ck_rise) begin
        cke_prev_ff <= cke_s;
      end
      unique case (pst_ff)
        PST_IDLE: if (ck_rise && cke_prev_ff && !cke_s) begin
          if (open_ff != '0) begin
            pst_ff <= PST_APD;
          end else if (dec == CMD_REF) begin
            pst_ff <= PST_SREF;
          end else begin
            pst_ff <= PST_PPD;
          end
        end
        PST_PPD, PST_APD: if (ck_rise && cke_s) begin
          pst_ff <= PST_IDLE;
        end
        PST_SREF: if (cke_rise_async) begin
          pst_ff <= PST_IDLE;
        end
        default: pst_ff <= PST_IDLE;
      endcase
    end
  end

  // buffer gating and write data capture
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_buf_en     <= 1'b0;
      o_odt_on     <= 1'b0;
      o_pstate     <= 3'h0;
      o_bank_open  <= '0;
      wr_window_ff <= 1'b0;
      o_wr_vld     <= 1'b0;
      o_wr_data    <= '0;
    end else begin
      o_buf_en    <= (pst_ff == PST_IDLE);
      o_odt_on    <= (pst_ff != PST_SREF) && odt_s;
      o_pstate    <= pst_ff;
      o_bank_open <= open_ff;
      if (live_edge && cke_s && dec == CMD_WR) begin
        wr_window_ff <= 1'b1;
      end else if (live_edge && cke_s && dec != CMD_NOP) begin
        wr_window_ff <= 1'b0;
      end
      o_wr_vld <= 1'b0;
      if (wr_window_ff && dqs_edge && pst_ff == PST_IDLE) begin
        o_wr_vld  <= 1'b1;
        o_wr_data <= dq_s;
      end
    end
  end

  // device drives read data lanes in every power state; strobe held idle
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      link.dq_d       <= '0;
      link.dqs_d      <= 1'b0;
      link.dqs_oe_n_d <= 1'b1;
    end else begin
      link.dq_d       <= i_rd_data;
      link.dqs_d      <= 1'b0;
      link.dqs_oe_n_d <= 1'b1;
    end
  end
endmodule

/* File: ddr3_host_end.sv */
// controller end: makes ck by divider and issues one command per ck period
`timescale 1ns/1ps
module ddr3_host_end
  import ddr3_fe_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_arst_n,
  ddr3_ca_if.host                link,
  input  wire logic              i_req,
  input  wire logic [3:0]        i_cmd,
  input  wire logic [BANK_W-1:0] i_bank,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_cke,
  input  wire logic              i_odt,
  input  wire logic [DQ_W-1:0]   i_wr_data,
  output logic                   o_busy
);
  logic [3:0]        div_ff;
  logic              pend_ff;
  logic [3:0]        cmd_ff;
  logic [BANK_W-1:0] bank_ff;
  logic [ADDR_W-1:0] addr_ff;

  // ck toggles every CK_HALF mclk cycles; commands change on ck falling
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_ff    <= 4'h0;
      link.ck   <= 1'b0;
      link.ck_n <= 1'b1;
    end else if (div_ff == 4'(CK_HALF - 1)) begin
      div_ff    <= 4'h0;
      link.ck   <= ~link.ck;
      link.ck_n <= link.ck;
    end else begin
      div_ff <= div_ff + 4'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend_ff <= 1'b0;
      cmd_ff  <= 4'h7;
      bank_ff <= '0;
      addr_ff <= '0;
    end else if (i_req && !pend_ff) begin
      pend_ff <= 1'b1;
      cmd_ff  <= i_cmd;
      bank_ff <= i_bank;
      addr_ff <= i_addr;
    end else if (pend_ff && link.ck && div_ff == 4'(CK_HALF - 1)) begin
      pend_ff <= 1'b0;
    end
  end

  // drive link mid-way between rising edges so it is stable at the crossing
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      link.cke   <= 1'b0;
      link.cs_n  <= 1'b1;
      link.ras_n <= 1'b1;
      link.cas_n <= 1'b1;
      link.we_n  <= 1'b1;
      link.ba    <= '0;
      link.a     <= '0;
      link.odt   <= 1'b0;
      o_busy     <= 1'b0;
    end else begin
      o_busy <= pend_ff;
      if (link.ck && div_ff == 4'(CK_HALF - 1)) begin
        link.cke <= i_cke | (pend_ff && (cmd_ff == 4'h4 || cmd_ff == 4'h5));
        link.odt <= i_odt;
        link.cs_n <= !pend_ff;
        {link.ras_n, link.cas_n, link.we_n} <= pend_ff ? cmd_ff[2:0] : 3'h7;
        link.ba <= bank_ff;
        link.a  <= addr_ff;
      end
    end
  end

  // write data toggles strobe each ck half period
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      link.dq_h       <= '0;
      link.dqs_h      <= 1'b0;
      link.dqs_oe_n_h <= 1'b1;
    end else if (div_ff == 4'(CK_HALF / 2)) begin
      link.dq_h       <= i_wr_data;
      link.dqs_h      <= ~link.dqs_h;
      link.dqs_oe_n_h <= 1'b0;
    end
  end
endmodule

/* File: ddr3_link_sva.sv */
// checker for the controller-to-device command link
`timescale 1ns/1ps
module ddr3_link_sva
  import ddr3_fe_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_arst_n,
  input  wire logic              ck,
  input  wire logic              ck_n,
  input  wire logic              cke,
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic [BANK_W-1:0] ba,
  input  wire logic [ADDR_W-1:0] a,
  input  wire logic              dqs_oe_n_d
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  logic [ADDR_W+BANK_W+3:0] pins;
  assign pins = {cs_n, ras_n, cas_n, we_n, ba, a};
  sequence s_ck_high; ck [*8]; endsequence
  sequence s_cs_held; !cs_n [*8]; endsequence
  property p_ck_half; $rose(ck) |-> s_ck_high ##1 !ck; endproperty
  property p_ck_pair; ck_n != ck; endproperty
  property p_pins_low; $changed(pins) |-> !ck; endproperty
  property p_pins_rise; $rose(ck) |-> $stable(pins); endproperty
  property p_cke_sync; $fell(cke) |-> !ck; endproperty
  property p_cs_one; $fell(cs_n) |-> s_cs_held ##[1:12] cs_n; endproperty
  property p_rw_cke; $rose(ck) && !cs_n && ras_n && !cas_n |-> cke; endproperty
  property p_dev_quiet; dqs_oe_n_d; endproperty
  a_ck_half:   assert property (p_ck_half) else $error("ck high phase wrong");
  a_ck_pair:   assert property (p_ck_pair) else $error("ck pair not inverse");
  a_pins_low:  assert property (p_pins_low) else $error("pins moved with ck high");
  a_pins_rise: assert property (p_pins_rise) else $error("pins moved at ck rise");
  a_cke_sync:  assert property (p_cke_sync) else $error("cke fell with ck high");
  a_cs_one:    assert property (p_cs_one) else $error("chip select window wrong");
  a_rw_cke:    assert property (p_rw_cke) else $error("cke low on access");
  a_dev_quiet: assert property (p_dev_quiet) else $error("device drove strobe");
endmodule

/* File: tb_ddr3_command_address_frontend.sv */
// self-checking bench: host end and device end joined by the link
`timescale 1ns/1ps
module tb_ddr3_command_address_frontend;
  import ddr3_fe_pkg::*;
  logic i_mclk, i_arst_n, i_req, i_cke, i_odt, o_busy;
  logic [3:0] i_cmd;
  logic [BANK_W-1:0] i_bank;
  logic [ADDR_W-1:0] i_addr;
  logic [DQ_W-1:0] i_wr_data, i_rd_data, o_wr_data, wr_last;
  logic [3:0] o_cmd_code, o_cl, o_cwl;
  logic o_cmd_vld, o_auto_pre, o_chop, o_buf_en, o_odt_on, o_interleave, o_ppd_fast, o_wr_vld, seen;
  logic [BANK_W-1:0] o_cmd_bank;
  logic [ADDR_W-1:0] o_cmd_addr;
  logic [NBANK-1:0] o_bank_open;
  logic [2:0] o_pstate;
  logic [1:0] o_al, o_bl_mode;
  logic [4:0] o_wr_rec;
  int fail_count, check_count, cyc, wr_n;
  ddr3_ca_if link();
  ddr3_host_end i_ddr3_host_end (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .link     (link),
    .i_req    (i_req),
    .i_cmd    (i_cmd),
    .i_bank   (i_bank),
    .i_addr   (i_addr),
    .i_cke    (i_cke),
    .i_odt    (i_odt),
    .i_wr_data(i_wr_data),
    .o_busy   (o_busy)
  );
  ddr3_dev_end i_ddr3_dev_end (
    .i_mclk      (i_mclk),
    .i_arst_n    (i_arst_n),
    .link        (link),
    .i_rd_data   (i_rd_data),
    .o_cmd_code  (o_cmd_code),
    .o_cmd_vld   (o_cmd_vld),
    .o_cmd_bank  (o_cmd_bank),
    .o_cmd_addr  (o_cmd_addr),
    .o_auto_pre  (o_auto_pre),
    .o_chop      (o_chop),
    .o_bank_open (o_bank_open),
    .o_pstate    (o_pstate),
    .o_buf_en    (o_buf_en),
    .o_odt_on    (o_odt_on),
    .o_cl        (o_cl),
    .o_cwl       (o_cwl),
    .o_al        (o_al),
    .o_bl_mode   (o_bl_mode),
    .o_interleave(o_interleave),
    .o_wr_rec    (o_wr_rec),
    .o_ppd_fast  (o_ppd_fast),
    .o_wr_data   (o_wr_data),
    .o_wr_vld    (o_wr_vld)
  );
  ddr3_link_sva i_ddr3_link_sva (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .ck(link.ck), .ck_n(link.ck_n),
    .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
    .ba(link.ba), .a(link.a), .dqs_oe_n_d(link.dqs_oe_n_d));
  initial begin
    i_mclk = 0;
    forever #5 i_mclk = ~i_mclk;
  end
  task summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one command through the host; vis x means no pulse check
  task issue(input logic [3:0] c, input logic [2:0] b, input logic [12:0] ad, input logic k, input logic vis);
    int n;
    @(posedge i_mclk);
    seen = 0;
    i_req <= 1;
    i_cmd <= c;
    i_bank <= b;
    i_addr <= ad;
    i_cke <= k;
    @(posedge i_mclk);
    i_req <= 0;
    for (n = 0; n < 48 && seen !== 1; n++) @(posedge i_mclk);
    if (vis !== 1'bx) chk(seen, vis);
    for (n = 0; n < 48 && o_busy !== 0; n++) @(posedge i_mclk);
    repeat (16) @(posedge i_mclk);
  endtask
  // fixed settle covers sync and one full ck period
  task pw(input logic k, input logic [2:0] st);
    @(posedge i_mclk);
    i_cke <= k;
    repeat (40) @(posedge i_mclk);
    chk(o_pstate, st);
  endtask
  always @(posedge i_mclk) begin
    if (o_cmd_vld === 1) seen <= 1;
    if (o_wr_vld === 1) begin
      wr_n <= wr_n + 1;
      wr_last <= o_wr_data;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    i_arst_n = 0; i_req = 0; i_cmd = 4'h7; i_bank = 0; i_addr = 0; i_cke = 1; i_odt = 0;
    i_wr_data = 16'hbeef; i_rd_data = 0; seen = 0; wr_n = 0; cyc = 0; wr_last = 0;
    repeat (5) @(posedge i_mclk);
    i_arst_n <= 1;
    repeat (2) @(posedge i_mclk);
    chk(o_cl, CL_RST); chk(o_cwl, CWL_RST); chk(o_wr_rec, WR_RST);
    chk(o_pstate, 3'h0); chk(o_bank_open, 8'h00);
    issue(4'h0, MR0_SEL, 13'h1049, 1, 1);
    chk(o_cl, 4'h9); chk(o_bl_mode, BL_OTF); chk(o_interleave, 1);
    chk(o_ppd_fast, 1); chk(o_cmd_code, 4'h0);
    chk(o_wr_rec, 5'h10);
    issue(4'h0, MR1_SEL, 13'h0008, 1, 1);
    chk(o_al, AL_CLM1);
    issue(4'h0, MR1_SEL, 13'h0018, 1, 1);
    chk(o_al, AL_CLM1);
    issue(4'h0, MR2_SEL, 13'h0020, 1, 1);
    chk(o_cwl, 4'h9);
    for (int b = 0; b < NBANK; b++) begin
      issue(4'h3, b[2:0], 13'h1abc, 1, 1);
      chk(o_cmd_code, 4'h3); chk(o_cmd_bank, b[2:0]);
      chk(o_cmd_addr, 13'h1abc); chk(o_bank_open, 16'((1 << (b + 1)) - 1));
    end
    issue(4'h0, MR2_SEL, 13'h0008, 1, 1);
    chk(o_cwl, 4'h9);
    issue(4'h5, 3'h3, 13'h05a5, 1, 1);
    chk(o_cmd_code, 4'h5); chk(o_cmd_addr, 13'h01a5);
    chk(o_auto_pre, 1); chk(o_chop, 1);
    issue(4'h4, 3'h5, 13'h12c3, 1, 1);
    chk(o_cmd_code, 4'h4); chk(o_cmd_addr, 13'h02c3); chk(o_cmd_bank, 3'h5);
    chk(o_auto_pre, 0); chk(o_chop, 0);
    chk(wr_last, 16'hbeef); chk(wr_n >= 2, 1);
    i_odt <= 1;
    pw(0, 3'h2);
    chk(o_odt_on, 1); chk(o_buf_en, 0);
    pw(1, 3'h0);
    chk(o_buf_en, 1);
    issue(4'h2, 3'h0, 13'h0400, 1, 1);
    chk(o_bank_open, 8'h00);
    pw(0, 3'h1);
    pw(1, 3'h0);
    // refresh issued with cke falling enters self-refresh
    issue(4'h1, 3'h0, 13'h0000, 0, 1'bx);
    chk(o_pstate, 3'h3); chk(o_buf_en, 0); chk(o_odt_on, 0);
    pw(1, 3'h0);
    issue(4'h3, 3'h6, 13'h0123, 1, 1);
    chk(o_bank_open, 8'h40);
    summarize();
  end
endmodule
